// ==== dsp_host_model.sv ====
// Host controller model: sends characters and decodes the port's output
`timescale 1ns/1ps
module dsp_host_model (
    input  wire logic       core_clk,
    output logic            rxd,
    input  wire logic       txd,
    input  wire integer     cyc,
    input  wire logic [3:0] fmt
);
    // ************
    // Character framing
    // ************
    logic [8:0] got_q[$];

    initial rxd = 1'b1;

    function automatic int nbits(input logic [3:0] f);
        return (f >= 4'h3) ? 8 : 7;
    endfunction

    // Codes 1,4,7 even and 2,5,8 odd; parity covers only the sent bits
    function automatic logic par_of(input logic [3:0] f, input logic [7:0] v);
        logic p;
        p = ^(v & ((nbits(f) == 8) ? 8'hff : 8'h7f));
        return (f % 3 == 2) ? ~p : p;
    endfunction

    task automatic send(input logic [7:0] v);
        rxd <= 1'b0;
        repeat (cyc) @(posedge core_clk);
        for (int i = 0; i < nbits(fmt); i++) begin
            rxd <= v[i];
            repeat (cyc) @(posedge core_clk);
        end
        if (fmt % 3 != 0) begin
            rxd <= par_of(fmt, v);
            repeat (cyc) @(posedge core_clk);
        end
        rxd <= 1'b1;
        repeat ((fmt % 3 == 0) ? 2 * cyc : cyc) @(posedge core_clk);
    endtask

    // Samples mid-bit, so a wrong bit period corrupts the decoded value
    initial begin
        logic [7:0] v;
        logic       ok;
        forever begin
            @(negedge txd);
            v = 8'h00;
            repeat (cyc / 2) @(posedge core_clk);
            ok = !txd;
            for (int i = 0; i < nbits(fmt); i++) begin
                repeat (cyc) @(posedge core_clk);
                v[i] = txd;
            end
            if (fmt % 3 != 0) begin
                repeat (cyc) @(posedge core_clk);
                ok = ok && (txd === par_of(fmt, v));
            end
            repeat ((fmt % 3 == 0) ? 2 : 1) begin
                repeat (cyc) @(posedge core_clk);
                ok = ok && (txd === 1'b1);
            end
            got_q.push_back({ok, v});
        end
    end
endmodule

// ==== dsp_pkg.sv ====
// Package: constants, types and helpers of the drive serial port
package dsp_pkg;

    // ************
    // Clock and line rates
    // ************
    localparam int CLK_HZ   = 200_000_000;
    localparam int BPS_4800 = 4800;
    localparam int BPS_9600 = 9600;
    localparam int BPS_19K2 = 19200;
    // Nearest whole cycle per bit; error stays well under 0.01 %
    localparam int CYC_4800 = (CLK_HZ + BPS_4800 / 2) / BPS_4800;
    localparam int CYC_9600 = (CLK_HZ + BPS_9600 / 2) / BPS_9600;
    localparam int CYC_19K2 = (CLK_HZ + BPS_19K2 / 2) / BPS_19K2;
    localparam int GAP_BITS = 35;

    // ************
    // Register offsets
    // ************
    localparam logic [3:0] A_STATION = 4'h0;
    localparam logic [3:0] A_BAUD    = 4'h1;
    localparam logic [3:0] A_FRAME   = 4'h2;
    localparam logic [3:0] A_PROTO   = 4'h3;
    localparam logic [3:0] A_MASK    = 4'h4;
    localparam logic [3:0] A_COMM    = 4'h5;
    localparam logic [3:0] A_INPUTS  = 4'h6;
    localparam logic [3:0] A_STATUS  = 4'h7;
    localparam logic [3:0] A_RXDATA  = 4'h8;
    localparam logic [3:0] A_TXDATA  = 4'h9;

    // Status bit positions
    localparam int ST_PE    = 0;
    localparam int ST_FE    = 1;
    localparam int ST_OV    = 2;
    localparam int ST_RXAV  = 3;
    localparam int ST_TXBSY = 4;

    // ************
    // Reset values and codes
    // ************
    localparam logic [7:0] RST_STATION = 8'h01;
    localparam logic [1:0] RST_BAUD    = 2'h1;
    localparam logic [3:0] RST_FRAME   = 4'h5;
    localparam logic [1:0] RST_PROTO   = 2'h2;
    localparam logic [7:0] RST_MASK    = 8'h00;
    localparam logic [1:0] BAUD_MAX    = 2'h2;
    localparam logic [3:0] FRAME_MAX   = 4'h8;
    localparam logic [1:0] PROTO_SELF  = 2'h0;
    localparam logic [1:0] PROTO_M422  = 2'h1;
    localparam logic [1:0] PROTO_M485  = 2'h2;
    localparam logic [7:0] ASC_START   = 8'h3a;
    localparam logic [7:0] ASC_END     = 8'h0a;

    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} dsp_par_t;

    typedef struct packed {
        logic     eight;
        dsp_par_t par;
        logic     stop2;
        logic     rtu;
    } dsp_fmt_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } dsp_bus_t;

    function automatic dsp_fmt_t fmt_of(input logic [3:0] c);
        dsp_fmt_t f;
        f.eight = (c >= 4'h3);
        f.rtu   = (c >= 4'h6);
        f.stop2 = (c == 4'h0) || (c == 4'h3) || (c == 4'h6);
        case (c)
            4'h1, 4'h4, 4'h7: f.par = PAR_EVEN;
            4'h2, 4'h5, 4'h8: f.par = PAR_ODD;
            default:          f.par = PAR_NONE;
        endcase
        return f;
    endfunction

endpackage

// ==== dsp_serial_port.sv ====
// Drive serial port: receive FIFO, framing, address filter, input mux
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps

// ************
// Receive FIFO
// ************
module dsp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } dsp_fifo_st_t;

    dsp_fifo_st_t s_ff;
    dsp_fifo_st_t nxt_s;
    logic         push;
    logic         pop;

    assign in_ready  = (s_ff.cnt != D[AW:0]);
    assign out_valid = (s_ff.cnt != '0);
    assign out_data  = s_ff.mem[s_ff.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data;
            nxt_s.wp = s_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_s.rp = s_ff.rp + 1'b1;
        end
        nxt_s.cnt = s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (rst) begin
            nxt_s = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        s_ff <= nxt_s;
    end
endmodule

// ************
// Serial port top
// ************
module dsp_serial_port #(
    parameter int CYC_4800 = dsp_pkg::CYC_4800,
    parameter int CYC_9600 = dsp_pkg::CYC_9600,
    parameter int CYC_19K2 = dsp_pkg::CYC_19K2
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire dsp_pkg::dsp_bus_t bus,
    output logic [7:0]            rd_data,
    input  wire logic             rxd,
    output logic                  txd,
    output logic                  rs485_de,
    output logic [1:0]            link_mode,
    input  wire logic [7:0]       term_in,
    output logic [7:0]            din_eff
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } dsp_rx_t;

    typedef struct packed {
        logic       rx_s1;
        logic       rx_s2;
        logic [7:0] term_s1;
        logic [7:0] term_s2;
        logic [7:0] station;
        logic [1:0] baud;
        logic [3:0] frame;
        logic [1:0] proto;
        logic [7:0] mask;
        logic [7:0] comm;
        logic [7:0] din;
        logic [7:0] rdata;
        dsp_rx_t    rx_st;
        logic [15:0] rx_cnt;
        logic [3:0] rx_idx;
        logic [7:0] rx_sh;
        logic       rx_par;
        logic [5:0] idle;
        logic       rx_gap;
        logic       rx_pend;
        logic [7:0] rx_byte;
        logic       fr_on;
        logic [1:0] asc_n;
        logic [3:0] asc_hi;
        logic       pe;
        logic       fe;
        logic       ov;
        logic       tx_busy;
        logic [15:0] tx_cnt;
        logic [11:0] tx_sh;
        logic [3:0] tx_left;
        logic       txd;
    } dsp_st_t;

    dsp_st_t          s_ff;
    dsp_st_t          nxt_s;
    dsp_pkg::dsp_fmt_t fmt;
    logic [15:0]      per;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic             fifo_pop;
    logic [7:0]       fifo_out_data;

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        if (c >= 8'h41) begin
            return 4'(c - 8'h37);
        end
        return c[3:0];
    endfunction

    assign fmt      = dsp_pkg::fmt_of(s_ff.frame);
    assign fifo_pop = bus.re && (bus.addr == dsp_pkg::A_RXDATA);

    always_comb begin
        case (s_ff.baud) // Counters stop at 0, so reload period - 1
            2'h0:    per = CYC_4800[15:0] - 16'h0001;
            2'h2:    per = CYC_19K2[15:0] - 16'h0001;
            default: per = CYC_9600[15:0] - 16'h0001;
        endcase
    end

    dsp_fifo #(.W(8), .D(16)) u_rx_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (s_ff.rx_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (s_ff.rx_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    always_comb begin
        logic [7:0]  b;
        logic        ok;
        logic        push;
        logic [11:0] f;
        logic        pb;
        b    = '0;
        ok   = 1'b0;
        push = 1'b0;
        f    = '1;
        pb   = 1'b0;
        nxt_s = s_ff;
        nxt_s.rx_s1   = rxd;
        nxt_s.rx_s2   = s_ff.rx_s1;
        nxt_s.term_s1 = term_in;
        nxt_s.term_s2 = s_ff.term_s1;
        nxt_s.din = (s_ff.mask & s_ff.comm) | (~s_ff.mask & s_ff.term_s2);
        if (s_ff.rx_pend && fifo_in_ready) begin
            nxt_s.rx_pend = 1'b0;
        end

        // ************
        // Register port
        // ************
        if (bus.re) begin
            case (bus.addr)
                dsp_pkg::A_STATION: nxt_s.rdata = s_ff.station;
                dsp_pkg::A_BAUD:    nxt_s.rdata = {6'h00, s_ff.baud};
                dsp_pkg::A_FRAME:   nxt_s.rdata = {4'h0, s_ff.frame};
                dsp_pkg::A_PROTO:   nxt_s.rdata = {6'h00, s_ff.proto};
                dsp_pkg::A_MASK:    nxt_s.rdata = s_ff.mask;
                dsp_pkg::A_COMM:    nxt_s.rdata = s_ff.comm;
                dsp_pkg::A_INPUTS:  nxt_s.rdata = s_ff.din;
                dsp_pkg::A_STATUS:  nxt_s.rdata = {3'h0, s_ff.tx_busy,
                    fifo_out_valid, s_ff.ov, s_ff.fe, s_ff.pe};
                dsp_pkg::A_RXDATA:  nxt_s.rdata =
                    fifo_out_valid ? fifo_out_data : 8'h00;
                default:            nxt_s.rdata = 8'h00;
            endcase
        end
        if (bus.we) begin
            case (bus.addr)
                dsp_pkg::A_STATION: if (bus.wdata != 8'h00) begin
                    nxt_s.station = bus.wdata;
                end
                dsp_pkg::A_BAUD: if (bus.wdata <= 8'(dsp_pkg::BAUD_MAX)) begin
                    nxt_s.baud = bus.wdata[1:0];
                end
                dsp_pkg::A_FRAME: if (bus.wdata <= 8'(dsp_pkg::FRAME_MAX)) begin
                    nxt_s.frame = bus.wdata[3:0];
                end
                dsp_pkg::A_PROTO: if (bus.wdata <= 8'(dsp_pkg::PROTO_M485)) begin
                    nxt_s.proto = bus.wdata[1:0];
                end
                dsp_pkg::A_MASK:   nxt_s.mask = bus.wdata;
                dsp_pkg::A_COMM:   nxt_s.comm = bus.wdata;
                dsp_pkg::A_STATUS: begin
                    // Write one to clear; a same-cycle event sets it again
                    nxt_s.pe = s_ff.pe & ~bus.wdata[dsp_pkg::ST_PE];
                    nxt_s.fe = s_ff.fe & ~bus.wdata[dsp_pkg::ST_FE];
                    nxt_s.ov = s_ff.ov & ~bus.wdata[dsp_pkg::ST_OV];
                end
                dsp_pkg::A_TXDATA: if (!s_ff.tx_busy) begin
                    f[0] = 1'b0;
                    if (fmt.eight) begin
                        f[8:1] = bus.wdata;
                        pb = (^bus.wdata) ^ (fmt.par == dsp_pkg::PAR_ODD);
                        f[9] = (fmt.par == dsp_pkg::PAR_NONE) ? 1'b1 : pb;
                    end else begin
                        f[7:1] = bus.wdata[6:0];
                        pb = (^bus.wdata[6:0]) ^ (fmt.par == dsp_pkg::PAR_ODD);
                        f[8] = (fmt.par == dsp_pkg::PAR_NONE) ? 1'b1 : pb;
                    end
                    nxt_s.tx_busy = 1'b1;
                    nxt_s.tx_sh   = f;
                    nxt_s.tx_cnt  = per;
                    nxt_s.txd     = 1'b0;
                    nxt_s.tx_left = 4'(9 + {3'h0, fmt.eight}
                        + {3'h0, fmt.par != dsp_pkg::PAR_NONE}
                        + {3'h0, fmt.stop2});
                end
                default: ;
            endcase
        end

        // ************
        // Transmitter
        // ************
        if (s_ff.tx_busy) begin
            if (s_ff.tx_cnt != 16'h0000) begin
                nxt_s.tx_cnt = s_ff.tx_cnt - 16'h0001;
            end else if (s_ff.tx_left == 4'h1) begin
                nxt_s.tx_busy = 1'b0;
                nxt_s.txd     = 1'b1;
            end else begin
                nxt_s.tx_sh   = {1'b1, s_ff.tx_sh[11:1]};
                nxt_s.txd     = s_ff.tx_sh[1];
                nxt_s.tx_left = s_ff.tx_left - 4'h1;
                nxt_s.tx_cnt  = per;
            end
        end

        // ************
        // Receiver, sampled mid-bit
        // ************
        if (s_ff.rx_cnt != 16'h0000) begin
            nxt_s.rx_cnt = s_ff.rx_cnt - 16'h0001;
        end
        case (s_ff.rx_st)
            RX_IDLE: begin
                if (!s_ff.rx_s2) begin
                    nxt_s.rx_st  = RX_START;
                    nxt_s.rx_cnt = {1'b0, per[15:1]};
                    nxt_s.rx_gap = (s_ff.idle >= 6'(dsp_pkg::GAP_BITS));
                end else if (s_ff.rx_cnt == 16'h0000) begin
                    // Idle time is measured in bit periods for RTU framing
                    nxt_s.rx_cnt = per;
                    if (s_ff.idle != 6'h3f) begin
                        nxt_s.idle = s_ff.idle + 6'h01;
                    end
                end
            end
            RX_START: if (s_ff.rx_cnt == 16'h0000) begin
                // A start bit gone by mid-bit is taken as a glitch
                nxt_s.rx_st  = s_ff.rx_s2 ? RX_IDLE : RX_DATA;
                nxt_s.rx_cnt = per;
                nxt_s.rx_idx = 4'h0;
            end
            RX_DATA: if (s_ff.rx_cnt == 16'h0000) begin
                nxt_s.rx_sh  = {s_ff.rx_s2, s_ff.rx_sh[7:1]};
                nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
                nxt_s.rx_cnt = per;
                if (s_ff.rx_idx == (fmt.eight ? 4'h7 : 4'h6)) begin
                    nxt_s.rx_st = (fmt.par == dsp_pkg::PAR_NONE)
                        ? RX_STOP : RX_PAR;
                end
            end
            RX_PAR: if (s_ff.rx_cnt == 16'h0000) begin
                nxt_s.rx_par = s_ff.rx_s2;
                nxt_s.rx_cnt = per;
                nxt_s.rx_st  = RX_STOP;
            end
            RX_STOP: if (s_ff.rx_cnt == 16'h0000) begin
                b  = fmt.eight ? s_ff.rx_sh : {1'b0, s_ff.rx_sh[7:1]};
                ok = 1'b1;
                nxt_s.rx_st  = RX_IDLE;
                nxt_s.rx_cnt = per;
                nxt_s.idle   = 6'h00;
                if (!s_ff.rx_s2) begin
                    nxt_s.fe = 1'b1;
                    ok = 1'b0;
                end
                if ((fmt.par != dsp_pkg::PAR_NONE) && ((^b ^ s_ff.rx_par)
                    != (fmt.par == dsp_pkg::PAR_ODD))) begin
                    nxt_s.pe = 1'b1;
                    ok = 1'b0;
                end
            end
            default: nxt_s.rx_st = RX_IDLE;
        endcase

        // ************
        // Station filter: only frames for this station reach the FIFO
        // ************
        if (ok) begin
            if (fmt.rtu) begin
                if (s_ff.rx_gap) begin
                    nxt_s.fr_on = (b == s_ff.station);
                    push = (b == s_ff.station);
                end else begin
                    push = s_ff.fr_on;
                end
            end else if (b == dsp_pkg::ASC_START) begin
                nxt_s.fr_on = 1'b0;
                nxt_s.asc_n = 2'h1;
            end else if (s_ff.asc_n == 2'h1) begin
                nxt_s.asc_hi = hex_val(b);
                nxt_s.asc_n  = 2'h2;
            end else if (s_ff.asc_n == 2'h2) begin
                b = {s_ff.asc_hi, hex_val(b)};
                nxt_s.fr_on = (b == s_ff.station);
                push = (b == s_ff.station);
                nxt_s.asc_n = 2'h0;
            end else if (s_ff.fr_on) begin
                push = 1'b1;
                nxt_s.fr_on = (b != dsp_pkg::ASC_END);
            end
        end
        if (push) begin
            // No way to hold back the line, so a byte is lost while the last one still waits on a full FIFO
            if (nxt_s.rx_pend) begin
                nxt_s.ov = 1'b1;
            end else begin
                nxt_s.rx_pend = 1'b1;
                nxt_s.rx_byte = b;
            end
        end

        if (rst) begin
            nxt_s = '0;
            nxt_s.rx_s1   = 1'b1;
            nxt_s.rx_s2   = 1'b1;
            nxt_s.txd     = 1'b1;
            nxt_s.rx_st   = RX_IDLE;
            nxt_s.station = dsp_pkg::RST_STATION;
            nxt_s.baud    = dsp_pkg::RST_BAUD;
            nxt_s.frame   = dsp_pkg::RST_FRAME;
            nxt_s.proto   = dsp_pkg::RST_PROTO;
            nxt_s.mask    = dsp_pkg::RST_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        s_ff <= nxt_s;
    end

    assign rd_data   = s_ff.rdata;
    assign txd       = s_ff.txd;
    assign din_eff   = s_ff.din;
    assign link_mode = s_ff.proto;
    // Half-duplex driver enable only on the RS-485 link
    assign rs485_de  = s_ff.tx_busy && (s_ff.proto == dsp_pkg::PROTO_M485);
endmodule

// ==== dsp_serial_port_monitor.sv ====
// Port-level checker of the drive serial port, bound to its top module
`timescale 1ns/1ps
module dsp_serial_port_monitor (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire dsp_pkg::dsp_bus_t bus,
    input  wire logic [7:0]        rd_data,
    input  wire logic              rxd,
    input  wire logic              txd,
    input  wire logic              rs485_de,
    input  wire logic [1:0]        link_mode,
    input  wire logic [7:0]        term_in,
    input  wire logic [7:0]        din_eff
);
    // ************
    // Helper logic and assertions
    // ************
    logic [1:0] want_mode_ff;
    logic       mode_wr;
    logic       mode_bad;

    assign mode_wr  = bus.we && bus.addr == dsp_pkg::A_PROTO
                      && bus.wdata <= 8'h02;
    assign mode_bad = bus.we && bus.addr == dsp_pkg::A_PROTO
                      && bus.wdata > 8'h02;

    // Remembers the accepted code; checked two edges on to allow a copy flop
    always_ff @(posedge core_clk) begin
        if (mode_wr) begin
            want_mode_ff <= bus.wdata[1:0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_reset_vals: assert property (
        $fell(rst) |-> link_mode == 2'h2 && txd && !rs485_de
                       && din_eff == 8'h00) else $error("bad reset outputs");
    chk_mode_set: assert property (
        mode_wr |-> ##2 link_mode == want_mode_ff)
        else $error("link mode not taken");
    chk_mode_keep: assert property (
        mode_bad |=> $stable(link_mode) [*2])
        else $error("invalid link mode taken");
    chk_de_mode: assert property (
        rs485_de |-> link_mode == dsp_pkg::PROTO_M485)
        else $error("driver enable outside two-wire mode");
    chk_de_start: assert property (
        $rose(rs485_de) |-> !txd) else $error("enable without start bit");
    chk_din_settle: assert property (
        (!bus.we && $stable(term_in)) [*4] |=> $stable(din_eff))
        else $error("inputs move with no cause");
    chk_rd_hold: assert property (
        !bus.re |=> $stable(rd_data)) else $error("read data moved");
    chk_rd_unmap: assert property (
        bus.re && bus.addr >= dsp_pkg::A_TXDATA |=> rd_data == 8'h00)
        else $error("unreadable index returned data");
    chk_status_rsv: assert property (
        bus.re && bus.addr == dsp_pkg::A_STATUS |=> rd_data[7:5] == 3'h0)
        else $error("status spare bits set");

    cov_de_on:   cover property ($rose(rs485_de));
    cov_unmap:   cover property (bus.re && bus.addr > dsp_pkg::A_TXDATA);
    cov_mode_wr: cover property (mode_wr);
endmodule

bind dsp_serial_port dsp_serial_port_monitor mon_u (
    .core_clk(core_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
    .rxd(rxd), .txd(txd), .rs485_de(rs485_de), .link_mode(link_mode),
    .term_in(term_in), .din_eff(din_eff)
);

// ==== test_drive_serial_port_config.sv ====
// Self-checking bench of the drive serial port
`timescale 1ns/1ps
module test_drive_serial_port_config;
    // ************
    // Environment, model and tasks
    // ************
    localparam int C48 = 40;
    localparam int C96 = 20;
    localparam int C19 = 10;
    logic              core_clk;
    logic              rst;
    dsp_pkg::dsp_bus_t bus;
    logic [7:0]        rd_data;
    logic              rxd;
    logic              txd;
    logic              rs485_de;
    logic [1:0]        link_mode;
    logic [7:0]        term_in;
    logic [7:0]        din_eff;
    int                cyc;
    logic [3:0]        fmt;
    int                err_count;
    int                compares;
    int                exp_reg[6] = '{1, 1, 5, 2, 0, 0};
    int                exp_q[$];
    int                cycs[3] = '{C48, C96, C19};
    logic [31:0]       seed = 32'h0000003b;

    dsp_serial_port #(.CYC_4800(C48), .CYC_9600(C96), .CYC_19K2(C19)) dut_u (
        .core_clk(core_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
        .rxd(rxd), .txd(txd), .rs485_de(rs485_de), .link_mode(link_mode),
        .term_in(term_in), .din_eff(din_eff));
    dsp_host_model host_u (
        .core_clk(core_clk), .rxd(rxd), .txd(txd), .cyc(cyc), .fmt(fmt));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [7:0] got, input int exp, input string m);
        compares++;
        if (got !== exp[7:0]) begin
            err_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, m, got, exp[7:0]);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge core_clk);
        bus.we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge core_clk);
        bus.re <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic rdchk(input logic [3:0] a, input int exp, input string m);
        logic [7:0] d;
        rd(a, d);
        check(d, exp, m);
    endtask

    // Model drops out-of-range codes, so the old value must survive
    task automatic cfg(input logic [3:0] a, input logic [7:0] d);
        bit ok;
        ok = (a == dsp_pkg::A_STATION) ? d != 8'h00 :
             (a == dsp_pkg::A_FRAME) ? d <= 8'h08 :
             (a == dsp_pkg::A_BAUD || a == dsp_pkg::A_PROTO) ? d <= 8'h02 : 1;
        if (ok) exp_reg[a] = d;
        wr(a, d);
    endtask

    task automatic check_cfg();
        for (int i = 0; i < 6; i++) rdchk(4'(i), exp_reg[i], "config");
    endtask

    task automatic tally_and_finish();
        $display("Mismatches %0d in %0d compares", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end

    // ************
    // Scenarios
    // ************
    initial begin
        logic [7:0]  v;
        logic [7:0]  s;
        logic [31:0] r;
        logic        de_seen;
        int          n;
        logic [8:0]  got;
        rst = 1'b1;
        bus = '0;
        term_in = 8'h00;
        cyc = C96;
        fmt = 4'h5;
        err_count = 0;
        compares = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        check_cfg();
        r = rnd();
        @(posedge core_clk);
        term_in <= r[7:0];
        repeat (5) @(posedge core_clk);
        #1 check(din_eff, term_in, "terminal default");
        cfg(dsp_pkg::A_STATION, 8'h00);
        cfg(dsp_pkg::A_BAUD, 8'h03);
        cfg(dsp_pkg::A_FRAME, 8'h09);
        cfg(dsp_pkg::A_PROTO, 8'h03);
        check_cfg();
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            cfg(dsp_pkg::A_STATION, r[7:0]);
            cfg(dsp_pkg::A_BAUD, {6'h00, r[9:8]});
            cfg(dsp_pkg::A_FRAME, {4'h0, r[15:12]});
            cfg(dsp_pkg::A_PROTO, {6'h00, r[17:16]});
            check_cfg();
        end
        rdchk(4'hc, 0, "unmapped read");
        rdchk(dsp_pkg::A_TXDATA, 0, "transmit read");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            cfg(dsp_pkg::A_MASK, (i == 1) ? 8'hff : r[7:0]);
            cfg(dsp_pkg::A_COMM, r[15:8]);
            term_in <= r[23:16];
            repeat (5) @(posedge core_clk);
            n = (exp_reg[4] & exp_reg[5]) | (~exp_reg[4] & int'(r[23:16]));
            #1 check(din_eff, n, "input mux");
            rdchk(dsp_pkg::A_INPUTS, n, "input register");
        end
        for (int f = 0; f < 9; f++) begin
            cfg(dsp_pkg::A_BAUD, 8'(f % 3));
            cfg(dsp_pkg::A_FRAME, 8'(f));
            cfg(dsp_pkg::A_PROTO, 8'(f % 3));
            cyc = cycs[f % 3];
            fmt = 4'(f);
            @(posedge core_clk);
            #1 check({6'h00, link_mode}, f % 3, "link mode");
            r = rnd();
            v = r[7:0];
            de_seen = 1'b0;
            n = 0;
            wr(dsp_pkg::A_TXDATA, v);
            while (host_u.got_q.size() == 0 && n < 8000) begin
                @(posedge core_clk);
                n++;
                de_seen |= (rs485_de === 1'b1);
            end
            check({7'h00, de_seen}, f % 3 == 2, "driver enable");
            got = (host_u.got_q.size() > 0) ? host_u.got_q.pop_front() : 9'h000;
            check(got[7:0], (f < 3) ? v & 8'h7f : v, "sent data");
            check({7'h00, got[8]}, 1, "sent framing");
            n = 0;
            do begin
                rd(dsp_pkg::A_STATUS, s);
                n++;
            end while (s[dsp_pkg::ST_TXBSY] !== 1'b0 && n < 2000);
        end
        // Foreign frame first; FIFO then overfilled while nobody drains it
        cfg(dsp_pkg::A_STATION, 8'h01);
        cfg(dsp_pkg::A_BAUD, 8'h02);
        cfg(dsp_pkg::A_FRAME, 8'h07);
        cfg(dsp_pkg::A_PROTO, 8'h01);
        cyc = C19;
        fmt = 4'h7;
        repeat (40 * C19) @(posedge core_clk);
        host_u.send(8'h05);
        host_u.send(8'h66);
        repeat (40 * C19) @(posedge core_clk);
        host_u.send(8'h01);
        exp_q.push_back(1);
        for (int i = 0; i < 18; i++) begin
            r = rnd();
            exp_q.push_back(int'(r[7:0]));
            host_u.send(r[7:0]);
        end
        repeat (20) @(posedge core_clk);
        rdchk(dsp_pkg::A_STATUS, 8'h0c, "full status");
        n = 0;
        rd(dsp_pkg::A_STATUS, s);
        while (s[dsp_pkg::ST_RXAV] === 1'b1 && n < 19) begin
            rd(dsp_pkg::A_RXDATA, v);
            check(v, exp_q.pop_front(), "received data");
            n++;
            rd(dsp_pkg::A_STATUS, s);
        end
        check(8'(n), 17, "drained count");
        wr(dsp_pkg::A_STATUS, 8'h07);
        rdchk(dsp_pkg::A_STATUS, 8'h00, "cleared status");
        rdchk(dsp_pkg::A_RXDATA, 8'h00, "empty read");
        tally_and_finish();
    end
endmodule
